/* wld_core.sv */
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
module wld_core
    import wld_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire wld_pkg::wld_wb_req_t wb_req,
    output logic [wld_pkg::XW-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    input wire wld_pkg::wld_issue_t iss,
    output logic iss_ready,
    output logic [3:0] rd_base_idx,
    output logic [3:0] rd_off_idx,
    input wire logic [wld_pkg::XW-1:0] base_val,
    input wire logic [wld_pkg::XW-1:0] off_val,
    output logic mem_req_valid,
    input wire logic mem_req_ready,
    output logic [wld_pkg::XW-1:0] mem_addr,
    input wire logic mem_rsp_valid,
    input wire logic [wld_pkg::XW-1:0] mem_rsp_data,
    output wld_pkg::wld_wr_t dest_wr,
    output wld_pkg::wld_wr_t base_wr,
    output logic br_valid,
    output logic [wld_pkg::XW-1:0] br_target,
    output logic undef_pulse,
    output logic usage_fault,
    output logic redirect_valid,
    output wld_pkg::wld_kind_t redirect_kind
);
    import wld_pkg::*;

    function automatic wld_dec_t decode(input wld_issue_t i);
        wld_dec_t d;
        logic [15:0] h1;
        logic [15:0] h2;
        d = '0;
        d.kind = K_NONE;
        d.index = 1'b1;
        d.add = 1'b1;
        h1 = i.instr[31:16];
        h2 = i.instr[15:0];
        if (!i.wide)
        begin
            d.dest = {1'b0, h2[2:0]};
            d.base = {1'b0, h2[5:3]};
            if (h2[15:11] == OP16_IMM)
            begin
                d.kind = K_LOAD;
                d.imm = {25'h0000000, h2[10:6], 2'b00};
            end
            else if (h2[15:11] == OP16_SP)
            begin
                d.kind = K_LOAD;
                d.base = REG_SP;
                d.dest = {1'b0, h2[10:8]};
                d.imm = {22'h000000, h2[7:0], 2'b00};
            end
            else if (h2[15:11] == OP16_LIT)
            begin
                d.kind = K_LOAD;
                d.lit = 1'b1;
                d.dest = {1'b0, h2[10:8]};
                d.imm = {22'h000000, h2[7:0], 2'b00};
            end
            else if (h2[15:9] == OP16_REG)
            begin
                d.kind = K_LOAD;
                d.use_off = 1'b1;
                d.off = {1'b0, h2[8:6]};
            end
        end
        else
        begin
            d.dest = h2[15:12];
            d.base = h1[3:0];
            if (h1[15:8] == OP32_LIT_HI && h1[6:0] == OP32_LIT_LO)
            begin
                // Base field all ones in either wide form lands here
                d.kind = K_LOAD;
                d.lit = 1'b1;
                d.add = h1[7];
                d.imm = {20'h00000, h2[11:0]};
            end
            else if (h1[15:4] == OP32_OFF12)
            begin
                d.kind = K_LOAD;
                d.imm = {20'h00000, h2[11:0]};
            end
            else if (h1[15:4] == OP32_OFF8 && h2[11])
            begin
                d.index = h2[10];
                d.add = h2[9];
                d.wback = h2[8];
                d.imm = {24'h000000, h2[7:0]};
                if (h2[10] && h2[9] && !h2[8])
                    d.kind = K_UNPRIV;
                else if (d.base == REG_SP && h2[10:8] == 3'b011 && h2[7:0] == POP_IMM)
                    d.kind = K_POP;
                else if (!h2[10] && !h2[8])
                    d.kind = K_UNDEF;
                else
                    d.kind = K_LOAD;
            end
            else if (h1[15:4] == OP32_OFF8 && h2[11:6] == 6'h00)
            begin
                d.kind = K_LOAD;
                d.use_off = 1'b1;
                d.off = h2[3:0];
                d.shift = h2[5:4];
                d.unpred = (d.off == REG_SP) || (d.off == REG_PC);
            end
        end
        // Flagged only; the access still proceeds
        if ((d.wback && d.base == d.dest) || (d.dest == REG_PC && i.in_cond && !i.last_cond))
            d.unpred = 1'b1;
        return d;
    endfunction

    wld_state_t s;
    wld_state_t n;
    wld_dec_t dec;
    logic accept;
    logic [XW-1:0] base_sel;
    logic [XW-1:0] off_sel;
    logic [XW-1:0] oa;
    logic [XW-1:0] acc_addr;
    logic rsp_done;
    logic dest_pc;

    assign dec = decode(iss);
    assign iss_ready = (s.st == ST_IDLE) && s.ctrl_en;
    assign accept = iss.valid && iss_ready;
    assign rd_base_idx = dec.base;
    assign rd_off_idx = dec.off;
    assign base_sel = dec.lit ? {iss.pc[31:2], 2'b00} : base_val;
    assign off_sel = dec.use_off ? (off_val << dec.shift) : dec.imm;
    // Plain 32-bit add and subtract; carries are dropped on purpose
    assign oa = dec.add ? base_sel + off_sel : base_sel - off_sel;
    assign acc_addr = dec.index ? oa : base_sel;
    assign rsp_done = (s.st == ST_RSP) && mem_rsp_valid;
    assign dest_pc = s.dest == REG_PC;

    always_comb
    begin
        logic [EV_W-1:0] ev;
        logic [EV_W-1:0] clr;
        ev = '0;
        clr = '0;
        n = s;
        n.dest_wr.valid = 1'b0;
        n.base_wr.valid = 1'b0;
        n.br_valid = 1'b0;
        n.undef_p = 1'b0;
        n.usage_p = 1'b0;
        n.redir_p = 1'b0;
        case (s.st)
            ST_IDLE:
            begin
                if (accept)
                begin
                    case (dec.kind)
                        K_LOAD:
                        begin
                            n.st = ST_REQ;
                            n.mem_addr = acc_addr;
                            n.off_addr = oa;
                            n.dest = dec.dest;
                            n.base = dec.base;
                            n.wback = dec.wback && !dec.lit;
                            ev[EV_UNPRED] = dec.unpred;
                        end
                        K_UNPRIV, K_POP:
                        begin
                            n.redir_p = 1'b1;
                            n.redir_kind = dec.kind;
                            ev[EV_REDIR] = 1'b1;
                        end
                        K_UNDEF:
                        begin
                            n.undef_p = 1'b1;
                            ev[EV_UNDEF] = 1'b1;
                        end
                        default:
                        begin
                            n.st = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_REQ:
            begin
                if (mem_req_ready)
                    n.st = ST_RSP;
            end
            ST_RSP:
            begin
                if (mem_rsp_valid)
                begin
                    n.st = ST_IDLE;
                    n.last_addr = s.mem_addr;
                    ev[EV_DONE] = 1'b1;
                    if (s.wback)
                    begin
                        n.base_wr.valid = 1'b1;
                        n.base_wr.idx = s.base;
                        n.base_wr.data = s.off_addr;
                    end
                    if (!dest_pc)
                    begin
                        n.dest_wr.valid = 1'b1;
                        n.dest_wr.idx = s.dest;
                        n.dest_wr.data = mem_rsp_data;
                    end
                    else if (s.mem_addr[1:0] != 2'b00)
                        ev[EV_UNPRED] = 1'b1;
                    else if (!mem_rsp_data[0])
                    begin
                        n.usage_p = 1'b1;
                        ev[EV_USAGE] = 1'b1;
                    end
                    else
                    begin
                        n.br_valid = 1'b1;
                        n.br_target = {mem_rsp_data[31:1], 1'b0};
                    end
                end
            end
            default:
            begin
                n.st = ST_IDLE;
            end
        endcase
        // Write lands on the edge where the master sees ack
        n.ack = wb_req.cyc && wb_req.stb && !s.ack;
        if (wb_req.cyc && wb_req.stb && !s.ack)
        begin
            case (wb_req.adr)
                ADR_CTRL: n.rdat = {31'h00000000, s.ctrl_en};
                ADR_STAT: n.rdat = {27'h0000000, s.status};
                ADR_IEN: n.rdat = {27'h0000000, s.ien};
                ADR_LAST: n.rdat = s.last_addr;
                default: n.rdat = '0;
            endcase
        end
        if (wb_req.cyc && wb_req.stb && s.ack && wb_req.we && wb_req.sel[0])
        begin
            case (wb_req.adr)
                ADR_CTRL: n.ctrl_en = wb_req.dat[CTRL_EN_BIT];
                ADR_IEN: n.ien = wb_req.dat[EV_W-1:0];
                ADR_CLR: clr = wb_req.dat[EV_W-1:0];
                default: clr = '0;
            endcase
        end
        // A new event beats a clear in the same cycle
        n.status = (s.status & ~clr) | ev;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s <= '0;
            s.ctrl_en <= CTRL_EN_RST;
            s.ien <= IEN_RST;
        end
        else
            s <= n;
    end

    assign wb_dat_o = s.rdat;
    assign wb_ack_o = s.ack;
    assign irq = |(s.status & s.ien);
    assign mem_req_valid = s.st == ST_REQ;
    assign mem_addr = s.mem_addr;
    assign dest_wr = s.dest_wr;
    assign base_wr = s.base_wr;
    assign br_valid = s.br_valid;
    assign br_target = s.br_target;
    assign undef_pulse = s.undef_p;
    assign usage_fault = s.usage_p;
    assign redirect_valid = s.redir_p;
    assign redirect_kind = s.redir_kind;

    logic [15:0] ah1;
    logic [15:0] ah2;
    logic byte_form;
    logic [XW-1:0] lit_exp;
    logic [XW-1:0] reg_exp;
    assign ah1 = iss.instr[31:16];
    assign ah2 = iss.instr[15:0];
    assign byte_form = iss.wide && ah1[15:4] == OP32_OFF8 && ah2[11] && ah1[3:0] != REG_PC;
    assign lit_exp = {iss.pc[31:2], 2'b00} + {22'h000000, ah2[7:0], 2'b00};
    // The short register form has no shift field; those bits belong to the base index
    assign reg_exp = base_val + (off_val << (iss.wide ? ah2[5:4] : 2'b00));

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_short_imm;
        (accept && !iss.wide && ah2[15:11] == OP16_IMM) |-> dec.index && dec.add && !dec.wback
            && dec.imm == {25'h0000000, ah2[10:6], 2'b00};
    endproperty
    a_short_imm: assert property (p_short_imm) else $error("short imm decode");
    property p_sp_base;
        (accept && !iss.wide && ah2[15:11] == OP16_SP) |-> rd_base_idx == REG_SP && !dec.wback
            && dec.imm == {22'h000000, ah2[7:0], 2'b00};
    endproperty
    a_sp_base: assert property (p_sp_base) else $error("stack form decode");
    property p_wide12;
        (accept && iss.wide && ah1[15:4] == OP32_OFF12 && ah1[3:0] != REG_PC)
            |-> dec.imm == {20'h00000, ah2[11:0]} && dec.index && dec.add && !dec.wback;
    endproperty
    a_wide12: assert property (p_wide12) else $error("wide offset decode");
    property p_lit_sel;
        (accept && iss.wide && ah1[15:4] == OP32_OFF8 && ah1[3:0] == REG_PC)
            |-> dec.lit && dec.kind == K_LOAD && !dec.wback;
    endproperty
    a_lit_sel: assert property (p_lit_sel) else $error("base 15 not literal");
    property p_byte_mode;
        (accept && byte_form && dec.kind == K_LOAD)
            |-> dec.index == ah2[10] && dec.add == ah2[9] && dec.wback == ah2[8];
    endproperty
    a_byte_mode: assert property (p_byte_mode) else $error("byte form mode bits");
    property p_undef;
        (accept && byte_form && !ah2[10] && !ah2[8]) |-> ##1 undef_pulse ##1 !undef_pulse;
    endproperty
    a_undef: assert property (p_undef) else $error("undefined not flagged");
    property p_unpriv;
        (accept && byte_form && ah2[10:8] == 3'b110)
            |-> ##1 redirect_valid && redirect_kind == K_UNPRIV && !mem_req_valid;
    endproperty
    a_unpriv: assert property (p_unpriv) else $error("unprivileged redirect");
    property p_pop;
        (accept && byte_form && ah1[3:0] == REG_SP && ah2[10:0] == 11'h304)
            |-> ##1 redirect_valid && redirect_kind == K_POP;
    endproperty
    a_pop: assert property (p_pop) else $error("pop redirect");
    property p_wback;
        (rsp_done && s.wback) |-> ##1 base_wr.valid && base_wr.data == $past(s.off_addr);
    endproperty
    a_wback: assert property (p_wback) else $error("base writeback");
    property p_pc_align;
        (rsp_done && dest_pc && s.mem_addr[1:0] != 2'b00) |-> ##1 !br_valid && !dest_wr.valid;
    endproperty
    a_pc_align: assert property (p_pc_align) else $error("misaligned pc load");
    property p_usage;
        (rsp_done && dest_pc && s.mem_addr[1:0] == 2'b00 && !mem_rsp_data[0])
            |-> ##1 usage_fault && !br_valid;
    endproperty
    a_usage: assert property (p_usage) else $error("usage fault missing");
    property p_lit_base;
        (accept && !iss.wide && ah2[15:11] == OP16_LIT) |-> ##1 mem_req_valid
            && mem_addr == $past(lit_exp);
    endproperty
    a_lit_base: assert property (p_lit_base) else $error("literal address");
    property p_reg_off;
        (accept && dec.kind == K_LOAD && dec.use_off && !dec.lit) |-> ##1 mem_addr == $past(reg_exp);
    endproperty
    a_reg_off: assert property (p_reg_off) else $error("register offset address");
endmodule

/* wld_pkg.sv */
package wld_pkg;
    localparam int XW = 32;
    localparam int WB_AW = 8;
    localparam int EV_W = 5;
    localparam logic [WB_AW-1:0] ADR_CTRL = 8'h00;
    localparam logic [WB_AW-1:0] ADR_STAT = 8'h04;
    localparam logic [WB_AW-1:0] ADR_CLR = 8'h08;
    localparam logic [WB_AW-1:0] ADR_IEN = 8'h0C;
    localparam logic [WB_AW-1:0] ADR_LAST = 8'h10;
    localparam int EV_UNDEF = 0;
    localparam int EV_UNPRED = 1;
    localparam int EV_USAGE = 2;
    localparam int EV_REDIR = 3;
    localparam int EV_DONE = 4;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [EV_W-1:0] IEN_RST = 5'h00;
    localparam logic [3:0] REG_SP = 4'hD;
    localparam logic [3:0] REG_PC = 4'hF;
    localparam logic [7:0] POP_IMM = 8'h04;
    localparam logic [4:0] OP16_IMM = 5'h0D;
    localparam logic [4:0] OP16_SP = 5'h13;
    localparam logic [4:0] OP16_LIT = 5'h09;
    localparam logic [6:0] OP16_REG = 7'h2C;
    localparam logic [11:0] OP32_OFF12 = 12'hF8D;
    localparam logic [11:0] OP32_OFF8 = 12'hF85;
    localparam logic [7:0] OP32_LIT_HI = 8'hF8;
    localparam logic [6:0] OP32_LIT_LO = 7'h5F;

    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_REQ = 2'b01, ST_RSP = 2'b11} wld_st_t;
    typedef enum logic [2:0] {K_NONE, K_LOAD, K_UNPRIV, K_POP, K_UNDEF} wld_kind_t;

    typedef struct packed {
        logic valid;
        logic wide;
        logic [XW-1:0] instr;
        logic [XW-1:0] pc;
        logic in_cond;
        logic last_cond;
    } wld_issue_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [WB_AW-1:0] adr;
        logic [XW-1:0] dat;
    } wld_wb_req_t;

    typedef struct packed {
        logic valid;
        logic [3:0] idx;
        logic [XW-1:0] data;
    } wld_wr_t;

    typedef struct packed {
        wld_kind_t kind;
        logic [3:0] base;
        logic [3:0] off;
        logic [3:0] dest;
        logic [XW-1:0] imm;
        logic use_off;
        logic lit;
        logic [1:0] shift;
        logic index;
        logic add;
        logic wback;
        logic unpred;
    } wld_dec_t;

    typedef struct packed {
        wld_st_t st;
        logic ctrl_en;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] ien;
        logic [XW-1:0] last_addr;
        logic ack;
        logic [XW-1:0] rdat;
        logic [XW-1:0] mem_addr;
        logic [XW-1:0] off_addr;
        logic [3:0] dest;
        logic [3:0] base;
        logic wback;
        wld_wr_t dest_wr;
        wld_wr_t base_wr;
        logic br_valid;
        logic [XW-1:0] br_target;
        logic undef_p;
        logic usage_p;
        logic redir_p;
        wld_kind_t redir_kind;
    } wld_state_t;
endpackage

/* wld_mem.sv */
`timescale 1ns/10ps
module wld_mem
    import wld_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic flip_lsb,
    input wire logic mem_req_valid,
    output logic mem_req_ready,
    input wire logic [wld_pkg::XW-1:0] mem_addr,
    output logic mem_rsp_valid,
    output logic [wld_pkg::XW-1:0] mem_rsp_data
);
    logic [2:0] stall;
    logic [2:0] lag;
    logic pend;
    logic [XW-1:0] word;
    // Word read back is the inverted address, with bit 0 left uninverted while flip_lsb is set, so a wrong address shows in the data
    assign mem_req_ready = mem_req_valid && stall == 3'h0;
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stall <= 3'h0;
            lag <= 3'h0;
            pend <= 1'b0;
            word <= '0;
            mem_rsp_valid <= 1'b0;
            mem_rsp_data <= 32'h5A5A_0F0F;
        end
        else
        begin
            // Data toggles outside a response so a stale word never matches
            mem_rsp_valid <= 1'b0;
            mem_rsp_data <= ~mem_rsp_data;
            if (!mem_req_valid)
                stall <= slow ? 3'h3 : 3'h0;
            else if (stall != 3'h0)
                stall <= stall - 3'h1;
            if (mem_req_ready)
            begin
                pend <= 1'b1;
                lag <= slow ? 3'h4 : 3'h0;
                word <= ~mem_addr ^ {31'h0, flip_lsb};
            end
            else if (pend && lag != 3'h0)
                lag <= lag - 3'h1;
            else if (pend)
            begin
                pend <= 1'b0;
                mem_rsp_valid <= 1'b1;
                mem_rsp_data <= word;
            end
        end
    end
endmodule

/* tb.sv */
`timescale 1ns/10ps
module tb;
    import wld_pkg::*;
    logic core_clk, sys_rst, slow, flip_lsb, wb_ack_o, irq, iss_ready;
    logic mem_req_valid, mem_req_ready, mem_rsp_valid, br_valid;
    logic undef_pulse, usage_fault, redirect_valid;
    logic [3:0] rd_base_idx, rd_off_idx;
    logic [XW-1:0] wb_dat_o, base_val, off_val, mem_addr, mem_rsp_data, br_target;
    wld_wb_req_t wb_req;
    wld_issue_t iss;
    wld_wr_t dest_wr, base_wr, cap_dest, cap_base;
    wld_kind_t redirect_kind;
    int err_total, checks_done;
    logic [XW-1:0] cap_addr, cap_tgt, rdat;
    logic cap_br, cap_usage, cap_undef, cap_redir;
    logic [2:0] cap_kind;

    wld_core u_dut (.core_clk, .sys_rst, .wb_req, .wb_dat_o, .wb_ack_o, .irq, .iss,
        .iss_ready, .rd_base_idx, .rd_off_idx, .base_val, .off_val, .mem_req_valid,
        .mem_req_ready, .mem_addr, .mem_rsp_valid, .mem_rsp_data, .dest_wr, .base_wr,
        .br_valid, .br_target, .undef_pulse, .usage_fault, .redirect_valid, .redirect_kind);
    wld_mem u_mem (.core_clk, .sys_rst, .slow, .flip_lsb, .mem_req_valid, .mem_req_ready,
        .mem_addr, .mem_rsp_valid, .mem_rsp_data);

    function automatic logic [XW-1:0] rf(input logic [3:0] i);
        if (i == 4'h7)
            return 32'hFFFF_FFF0;
        if (i == 4'h2)
            return 32'h0000_0004;
        return 32'h1000_0000 + {20'h0, i, 8'h00};
    endfunction

    // Register file answers in the same cycle as the read index
    assign base_val = rf(rd_base_idx);
    assign off_val = rf(rd_off_idx);
    always #4 core_clk = ~core_clk;

    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        chk32(nm, {31'h0, e}, {31'h0, g});
    endtask

    task automatic give_verdict;
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        wb_req <= '{1'b1, 1'b1, we, 4'hF, a, d};
        // Ends on ack; with no timeout here, only the watchdog ends a wait for a missing ack
        do
            @(posedge core_clk);
        while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_req <= '0;
        @(posedge core_clk);
        chk1("wb_ack_drop", 1'b0, wb_ack_o);
    endtask

    task automatic run_ins(input logic w, input logic [31:0] ins, input logic [31:0] pc);
        int k;
        cap_addr = 32'h0BAD_0BAD;
        cap_dest = '0;
        cap_base = '0;
        {cap_br, cap_usage, cap_undef, cap_redir} = 4'h0;
        @(posedge core_clk);
        iss <= '{1'b1, w, ins, pc, 1'b0, 1'b0};
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (iss_ready !== 1'b1 && k < 50);
        iss.valid <= 1'b0;
        for (k = 0; k < 60; k++)
        begin
            @(posedge core_clk);
            if (mem_req_valid === 1'b1)
                cap_addr = mem_addr;
            if (dest_wr.valid === 1'b1)
                cap_dest = dest_wr;
            if (base_wr.valid === 1'b1)
                cap_base = base_wr;
            if (br_valid === 1'b1)
                {cap_br, cap_tgt} = {1'b1, br_target};
            cap_usage |= (usage_fault === 1'b1);
            cap_undef |= (undef_pulse === 1'b1);
            if (redirect_valid === 1'b1)
                {cap_redir, cap_kind} = {1'b1, redirect_kind};
            if (k > 0 && iss_ready === 1'b1)
                break;
        end
        chk1("iss_ready", 1'b1, iss_ready);
    endtask

    task automatic expect_ld(input logic [31:0] a, input logic [3:0] ti, input logic wb,
        input logic [3:0] bi, input logic [31:0] wv);
        chk32("mem_addr", a, cap_addr);
        chk32("dest_data", ~a, cap_dest.data);
        chk32("dest", {27'h0, 1'b1, ti}, {27'h0, cap_dest.valid, cap_dest.idx});
        chk32("wback", {27'h0, wb, bi}, {27'h0, cap_base.valid, cap_base.idx});
        if (wb)
            chk32("wback_data", wv, cap_base.data);
    endtask

    task automatic t_regs;
        wb_xfer(1'b0, ADR_CTRL, 32'h0);
        chk32("ctrl", 32'h1, rdat);
        wb_xfer(1'b0, ADR_IEN, 32'h0);
        chk32("ien", 32'h0, rdat);
        wb_xfer(1'b0, 8'h14, 32'h0);
        chk32("unmapped", 32'h0, rdat);
        wb_xfer(1'b1, ADR_CTRL, 32'h0);
        @(posedge core_clk);
        chk1("ready_off", 1'b0, iss_ready);
        wb_xfer(1'b1, ADR_CTRL, 32'h1);
    endtask

    task automatic t_short;
        run_ins(1'b0, {16'h0, OP16_IMM, 5'h1F, 3'h4, 3'h1}, 32'h0);
        expect_ld(rf(4'h4) + 32'd124, 4'h1, 1'b0, 4'h0, 32'h0);
        run_ins(1'b0, {16'h0, OP16_SP, 3'h2, 8'hFF}, 32'h0);
        expect_ld(rf(4'hD) + 32'd1020, 4'h2, 1'b0, 4'h0, 32'h0);
        run_ins(1'b0, {16'h0, OP16_LIT, 3'h4, 8'hFF}, 32'h0000_8006);
        expect_ld(32'h0000_8400, 4'h4, 1'b0, 4'h0, 32'h0);
        run_ins(1'b0, {16'h0, OP16_REG, 3'h3, 3'h4, 3'h1}, 32'h0);
        expect_ld(rf(4'h4) + rf(4'h3), 4'h1, 1'b0, 4'h0, 32'h0);
    endtask

    task automatic t_wide;
        run_ins(1'b1, {OP32_OFF12, 4'h5, 4'h3, 12'hFFF}, 32'h0);
        expect_ld(rf(4'h5) + 32'd4095, 4'h3, 1'b0, 4'h0, 32'h0);
        run_ins(1'b1, {OP32_OFF12, 4'h7, 4'h3, 12'h020}, 32'h0);
        expect_ld(32'h0000_0010, 4'h3, 1'b0, 4'h0, 32'h0);
        run_ins(1'b1, {OP32_OFF8, 4'h2, 4'h1, 4'hC, 8'h10}, 32'h0);
        expect_ld(32'hFFFF_FFF4, 4'h1, 1'b0, 4'h0, 32'h0);
        run_ins(1'b1, {OP32_OFF12, 4'hF, 4'h3, 12'h010}, 32'h0000_8002);
        expect_ld(32'h0000_8010, 4'h3, 1'b0, 4'h0, 32'h0);
        run_ins(1'b1, {OP32_LIT_HI, 1'b0, OP32_LIT_LO, 4'h3, 12'h010}, 32'h0000_8003);
        expect_ld(32'h0000_7FF0, 4'h3, 1'b0, 4'h0, 32'h0);
    endtask

    task automatic t_index;
        logic p, u, w;
        logic [31:0] oa;
        for (int m = 0; m < 8; m++)
        begin
            {p, u, w} = m[2:0];
            oa = u ? rf(4'h6) + 32'h20 : rf(4'h6) - 32'h20;
            run_ins(1'b1, {OP32_OFF8, 4'h6, 4'h1, 1'b1, p, u, w, 8'h20}, 32'h0);
            chk1("undef", !p && !w, cap_undef);
            chk1("redir", p && u && !w, cap_redir);
            if (p && u && !w)
                chk32("kind", {29'h0, K_UNPRIV}, {29'h0, cap_kind});
            if (p || w)
                chk1("no_load", p && u && !w, !cap_dest.valid);
            if (w)
                expect_ld(p ? oa : rf(4'h6), 4'h1, 1'b1, 4'h6, oa);
            else if (p && !u)
                expect_ld(oa, 4'h1, 1'b0, 4'h0, 32'h0);
        end
        run_ins(1'b1, {OP32_OFF8, REG_SP, 4'h1, 4'hB, POP_IMM}, 32'h0);
        chk1("pop", 1'b1, cap_redir);
        chk32("kind", {29'h0, K_POP}, {29'h0, cap_kind});
        run_ins(1'b1, {OP32_OFF8, REG_SP, 4'h1, 4'hB, 8'h08}, 32'h0);
        expect_ld(rf(4'hD), 4'h1, 1'b1, 4'hD, rf(4'hD) + 32'h8);
    endtask

    task automatic t_regoff;
        for (int s = 0; s < 4; s++)
        begin
            run_ins(1'b1, {OP32_OFF8, 4'h4, 4'h1, 6'h00, s[1:0], 4'h3}, 32'h0);
            expect_ld(rf(4'h4) + (rf(4'h3) << s), 4'h1, 1'b0, 4'h0, 32'h0);
        end
    endtask

    task automatic t_pc;
        slow <= 1'b1;
        run_ins(1'b1, {OP32_OFF12, 4'h4, REG_PC, 12'h000}, 32'h0);
        chk1("branch", 1'b1, cap_br);
        chk32("target", ~rf(4'h4) & 32'hFFFF_FFFE, cap_tgt);
        chk1("no_fault", 1'b0, cap_usage);
        flip_lsb <= 1'b1;
        wb_xfer(1'b1, ADR_CLR, 32'h1F);
        run_ins(1'b1, {OP32_OFF12, 4'h4, REG_PC, 12'h000}, 32'h0);
        chk1("fault", 1'b1, cap_usage);
        chk1("fault_nobr", 1'b0, cap_br);
        wb_xfer(1'b0, ADR_STAT, 32'h0);
        chk32("stat_usage", 32'h14, rdat);
        flip_lsb <= 1'b0;
        wb_xfer(1'b1, ADR_CLR, 32'h1F);
        run_ins(1'b1, {OP32_OFF12, 4'h4, REG_PC, 12'h001}, 32'h0);
        chk1("misaligned", 1'b0, cap_br | cap_dest.valid);
        wb_xfer(1'b0, ADR_STAT, 32'h0);
        chk32("stat_unpred", 32'h12, rdat);
        slow <= 1'b0;
    endtask

    task automatic t_irq;
        wb_xfer(1'b1, ADR_CLR, 32'h1F);
        run_ins(1'b0, {16'h0, OP16_IMM, 5'h01, 3'h4, 3'h1}, 32'h0);
        wb_xfer(1'b0, ADR_STAT, 32'h0);
        chk32("stat_done", 32'h10, rdat);
        wb_xfer(1'b0, ADR_LAST, 32'h0);
        chk32("last_addr", rf(4'h4) + 32'd4, rdat);
        wb_xfer(1'b1, ADR_CLR, 32'h1F);
        run_ins(1'b1, {OP32_OFF8, 4'h6, 4'h1, 4'h8, 8'h20}, 32'h0);
        wb_xfer(1'b0, ADR_STAT, 32'h0);
        chk32("stat_undef", 32'h01, rdat);
        chk1("irq_masked", 1'b0, irq);
        wb_xfer(1'b1, ADR_IEN, 32'h01);
        @(posedge core_clk);
        chk1("irq_on", 1'b1, irq);
        wb_xfer(1'b1, ADR_CLR, 32'h01);
        @(posedge core_clk);
        chk1("irq_off", 1'b0, irq);
    endtask

    initial
    begin
        {core_clk, sys_rst, slow, flip_lsb} = 4'h4;
        wb_req = '0;
        iss = '0;
        err_total = 0;
        checks_done = 0;
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_short();
        t_wide();
        t_index();
        t_regoff();
        t_pc();
        t_irq();
        give_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        give_verdict();
    end
endmodule
